/* File: core/sil_map.svh */
// status indicator block: register offsets, field positions, reset values, timing
// assumes byte addresses on an 8-bit register port with one 32-bit word per register
`ifndef SIL_MAP_SVH
`define SIL_MAP_SVH

// ********************
// register offsets
// ********************
`define SIL_OFF_CTRL 8'h00
`define SIL_OFF_SWVAL 8'h04
`define SIL_OFF_STATUS 8'h08
`define SIL_OFF_PDIR 8'h0c
`define SIL_OFF_PFSEL 8'h10
`define SIL_OFF_PBUF 8'h14
`define SIL_OFF_PDATA 8'h18
`define SIL_OFF_CNT_RX1 8'h20
`define SIL_OFF_CNT_ERR1 8'h24
`define SIL_OFF_CNT_RX2 8'h28
`define SIL_OFF_CNT_ERR2 8'h2c

// ********************
// field positions
// ********************
`define SIL_CTRL_SEL_LSB 0
`define SIL_CTRL_EN_LSB 8
`define SIL_CTRL_BYP_CLR 16
`define SIL_SW_ON_LSB 0
`define SIL_SW_U1_LSB 8
`define SIL_SW_U2_LSB 10
`define SIL_SPARE_BIT 7

// ********************
// reset values
// ********************
`define SIL_RST_CTRL 32'h00007f00
`define SIL_RST_SWVAL 32'h00000000
`define SIL_RST_PDIR 8'hff
`define SIL_RST_PFSEL 8'h00
`define SIL_RST_PBUF 32'h00009000
`define SIL_RST_PDATA 8'hff

// ********************
// timing
// ********************
`define SIL_CLK_MHZ 50
`define SIL_BLINK_HALF_MS 250

`endif

/* File: core/sil_pkg.sv */
// status indicator block: shared types
// assumes sil_map.svh holds every number
package sil_pkg;

   // user indicator drive mode
   typedef enum logic [1:0] {SIL_UM_OFF, SIL_UM_ON, SIL_UM_BLINK} sil_umode_e;

   // indicator select and enable index
   typedef enum logic [2:0] {
      SIL_IX_RUN, SIL_IX_DLINK, SIL_IX_ERR, SIL_IX_LER1, SIL_IX_LER2, SIL_IX_U1, SIL_IX_U2
   } sil_index_e;

endpackage : sil_pkg

/* File: core/sil_sync.sv */
// status indicator block: two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none

module sil_sync #(
   parameter int WIDTH = 2,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sil_sync_s;

   sil_sync_s state_reg;
   sil_sync_s state_next;

   always_comb begin
      state_next.meta = async_in;
      state_next.stable = state_reg.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= {INIT, INIT};
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.stable;

endmodule : sil_sync

`default_nettype wire

/* File: core/sil_blink.sv */
// status indicator block: free-running blink level generator
// assumes a single clock; half period set by parameter
`timescale 1ns/100ps
`default_nettype none

module sil_blink #(
   parameter int HALF_CYCLES = 12500000
) (
   input wire logic ref_clk,
   input wire logic resetn,
   output logic blink
);

   typedef struct packed {
      logic [31:0] count;
      logic level;
   } sil_blink_s;

   sil_blink_s state_reg;
   sil_blink_s state_next;

   always_comb begin
      state_next = state_reg;
      if (state_reg.count >= 32'(HALF_CYCLES - 1)) begin
         state_next.count = 32'h0;
         state_next.level = ~state_reg.level;
      end else begin
         state_next.count = state_reg.count + 32'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign blink = state_reg.level;

endmodule : sil_blink

`default_nettype wire

/* File: core/sil_indicator.sv */
// status indicator block: top level, drives all own-station and port indicators
// assumes status inputs come from logic on ref_clk, pins pass sil_sync first
//
// Behaviour
// - Operating indicator lit while running, dark after hardware failure or watchdog error.
// - Receive indicator lit while frames are received, dark otherwise.
// - Send indicator lit while frames are sent, dark otherwise.
// - Cyclic indicator steady when cyclic runs, blinks when link up only, off disconnected.
// - Station fault indicator lit on own station error, off in normal operation.
// - Port line fault lit on abnormal data or loopback; linkup lit when link up.
// - Power-on reset: all off; system reset: all off except receive and send.
// - On watchdog or own error: fault on unless system reset; operating, cyclic, user, line fault off.
// - In bypass mode the per-port linkup indicators are turned on, except during system reset.
// - Hardware-controlled indicators follow station status without software action.
// - Operating, cyclic, fault, line fault selectable hw or sw; user software only; others hardware only.
// - Spare bit floats high in reset and drives high during standby after.
// - Software can enable or disable each of seven indicator functions.
// - System reset, watchdog or own error puts the station into bypass mode.
// - Received and error frames counted per port, readable by software.
`timescale 1ns/100ps
`default_nettype none
`include "sil_map.svh"

module sil_indicator #(
   parameter int CNT_W = 16,
   parameter int BLINK_HALF_CYCLES = `SIL_BLINK_HALF_MS * 1000 * `SIL_CLK_MHZ
) (
   input wire logic ref_clk,
   input wire logic resetn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // own-station status
   input wire logic system_reset,
   input wire logic hw_failure,
   input wire logic int_watchdog_error,
   input wire logic own_station_error,
   input wire logic rx_active,
   input wire logic tx_active,
   input wire logic cyclic_running,
   input wire logic link_up_p1,
   input wire logic link_up_p2,
   input wire logic rx_abnormal_p1,
   input wire logic rx_abnormal_p2,
   input wire logic loopback_p1,
   input wire logic loopback_p2,
   input wire logic rx_frame_p1,
   input wire logic rx_err_frame_p1,
   input wire logic rx_frame_p2,
   input wire logic rx_err_frame_p2,
   // pins
   input wire logic external_watchdog_fault_n,
   input wire logic spare_port_bit_i,
   output logic spare_port_bit_o,
   output logic spare_port_bit_oe,
   // indicators
   output logic operating_indicator_n,
   output logic receive_indicator_n,
   output logic send_indicator_n,
   output logic cyclic_exchange_indicator_n,
   output logic station_fault_indicator_n,
   output logic custom_indicator_1_n,
   output logic custom_indicator_2_n,
   output logic port1_connected_out,
   output logic port2_connected_out,
   output logic port1_line_fault_n,
   output logic port2_line_fault_n,
   output logic bypass_mode
);
   import sil_pkg::*;

   // ********************
   // state
   // ********************
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] swval;
      logic [7:0] pdir;
      logic [7:0] pfsel;
      logic [31:0] pbuf;
      logic [7:0] pdata;
      logic standby;
      logic bypass;
      logic [CNT_W-1:0] cnt_rx1;
      logic [CNT_W-1:0] cnt_err1;
      logic [CNT_W-1:0] cnt_rx2;
      logic [CNT_W-1:0] cnt_err2;
      logic [31:0] rdata;
      logic run_n;
      logic rx_n;
      logic tx_n;
      logic dlink_n;
      logic err_n;
      logic u1_n;
      logic u2_n;
      logic link1_n;
      logic link2_n;
      logic ler1_n;
      logic ler2_n;
      logic spare_o;
      logic spare_oe;
   } sil_state_s;

   sil_state_s state_reg;
   sil_state_s state_next;

   logic [1:0] pin_sync;
   logic blink;
   logic ext_wdt;
   logic wdt_or_own;
   logic [6:0] sel;
   logic [6:0] en;
   logic [6:0] swon;
   logic run_lit;
   logic dlink_lit;
   logic err_lit;
   logic ler1_lit;
   logic ler2_lit;
   logic u1_lit;
   logic u2_lit;
   logic link1_lit;
   logic link2_lit;

   // ********************
   // helpers
   // ********************
   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic ev);
      sat_inc = (ev && (v != {CNT_W{1'b1}})) ? v + CNT_W'(1) : v;
   endfunction : sat_inc

   function automatic logic user_lit(input logic [1:0] mode, input logic blk);
      sil_umode_e m;
      m = sil_umode_e'(mode);
      case (m)
         SIL_UM_ON: user_lit = 1'b1;
         SIL_UM_BLINK: user_lit = blk;
         default: user_lit = 1'b0;
      endcase
   endfunction : user_lit

   function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
      widen = 32'(v);
   endfunction : widen

   // ********************
   // submodules
   // ********************
   sil_sync #(
      .WIDTH(2),
      .INIT(2'h3)
   ) u_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in({spare_port_bit_i, external_watchdog_fault_n}),
      .sync_out(pin_sync)
   );

   sil_blink #(
      .HALF_CYCLES(BLINK_HALF_CYCLES)
   ) u_blink (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .blink(blink)
   );

   // ********************
   // indicator logic
   // ********************
   assign ext_wdt = ~pin_sync[0];
   assign wdt_or_own = int_watchdog_error | ext_wdt | own_station_error;
   assign sel = state_reg.ctrl[`SIL_CTRL_SEL_LSB +: 7];
   assign en = state_reg.ctrl[`SIL_CTRL_EN_LSB +: 7];
   assign swon = state_reg.swval[`SIL_SW_ON_LSB +: 7];

   always_comb begin
      // hardware or software source per indicator
      run_lit = sel[SIL_IX_RUN] ? swon[SIL_IX_RUN] : ~hw_failure;
      dlink_lit = sel[SIL_IX_DLINK] ? swon[SIL_IX_DLINK] :
         (cyclic_running | ((link_up_p1 | link_up_p2) & blink));
      err_lit = sel[SIL_IX_ERR] ? swon[SIL_IX_ERR] : own_station_error;
      ler1_lit = sel[SIL_IX_LER1] ? swon[SIL_IX_LER1] : (rx_abnormal_p1 | loopback_p1);
      ler2_lit = sel[SIL_IX_LER2] ? swon[SIL_IX_LER2] : (rx_abnormal_p2 | loopback_p2);
      u1_lit = user_lit(state_reg.swval[`SIL_SW_U1_LSB +: 2], blink);
      u2_lit = user_lit(state_reg.swval[`SIL_SW_U2_LSB +: 2], blink);
      link1_lit = link_up_p1;
      link2_lit = link_up_p2;
      // software enable of each function
      run_lit = run_lit & en[SIL_IX_RUN];
      dlink_lit = dlink_lit & en[SIL_IX_DLINK];
      err_lit = err_lit & en[SIL_IX_ERR];
      ler1_lit = ler1_lit & en[SIL_IX_LER1];
      ler2_lit = ler2_lit & en[SIL_IX_LER2];
      u1_lit = u1_lit & en[SIL_IX_U1];
      u2_lit = u2_lit & en[SIL_IX_U2];
      // forced states on errors
      if (hw_failure | int_watchdog_error | ext_wdt) begin
         run_lit = 1'b0;
      end
      if (wdt_or_own) begin
         err_lit = 1'b1;
         run_lit = 1'b0;
         dlink_lit = 1'b0;
         u1_lit = 1'b0;
         u2_lit = 1'b0;
         ler1_lit = 1'b0;
         ler2_lit = 1'b0;
      end
      if (state_reg.bypass) begin
         link1_lit = 1'b1;
         link2_lit = 1'b1;
      end
      // system reset forces all off except receive and send
      if (system_reset) begin
         run_lit = 1'b0;
         dlink_lit = 1'b0;
         err_lit = 1'b0;
         u1_lit = 1'b0;
         u2_lit = 1'b0;
         ler1_lit = 1'b0;
         ler2_lit = 1'b0;
         link1_lit = 1'b0;
         link2_lit = 1'b0;
      end
   end

   // ********************
   // next state
   // ********************
   always_comb begin
      state_next = state_reg;
      state_next.rdata = 32'h0;

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            `SIL_OFF_CTRL: begin
               state_next.ctrl = {16'h0, reg_wdata[15:0]};
            end
            `SIL_OFF_SWVAL: begin
               state_next.swval = reg_wdata;
            end
            `SIL_OFF_PDIR: begin
               state_next.pdir = reg_wdata[7:0];
               state_next.standby = 1'b0;
            end
            `SIL_OFF_PFSEL: begin
               state_next.pfsel = reg_wdata[7:0];
            end
            `SIL_OFF_PBUF: begin
               state_next.pbuf = reg_wdata;
            end
            `SIL_OFF_PDATA: begin
               state_next.pdata = reg_wdata[7:0];
            end
            default: begin
            end
         endcase
      end

      // bypass: clear by software, cause sets and wins
      if (reg_wr && (reg_addr == `SIL_OFF_CTRL) && reg_wdata[`SIL_CTRL_BYP_CLR]) begin
         state_next.bypass = 1'b0;
      end
      if (system_reset | wdt_or_own) begin
         state_next.bypass = 1'b1;
      end

      // frame counters per port
      state_next.cnt_rx1 = sat_inc(state_reg.cnt_rx1, rx_frame_p1);
      state_next.cnt_err1 = sat_inc(state_reg.cnt_err1, rx_err_frame_p1);
      state_next.cnt_rx2 = sat_inc(state_reg.cnt_rx2, rx_frame_p2);
      state_next.cnt_err2 = sat_inc(state_reg.cnt_err2, rx_err_frame_p2);

      // register reads, data in the following cycle
      if (reg_rd) begin
         unique case (reg_addr)
            `SIL_OFF_CTRL: state_next.rdata = state_reg.ctrl;
            `SIL_OFF_SWVAL: state_next.rdata = state_reg.swval;
            `SIL_OFF_STATUS: state_next.rdata = {20'h0, state_reg.bypass,
               ~state_reg.ler2_n, ~state_reg.ler1_n, ~state_reg.link2_n, ~state_reg.link1_n,
               ~state_reg.u2_n, ~state_reg.u1_n, ~state_reg.err_n, ~state_reg.dlink_n,
               ~state_reg.tx_n, ~state_reg.rx_n, ~state_reg.run_n};
            `SIL_OFF_PDIR: state_next.rdata = {24'h0, state_reg.pdir};
            `SIL_OFF_PFSEL: state_next.rdata = {24'h0, state_reg.pfsel};
            `SIL_OFF_PBUF: state_next.rdata = state_reg.pbuf;
            `SIL_OFF_PDATA: state_next.rdata = {24'h0, pin_sync[1],
               state_reg.pdata[`SIL_SPARE_BIT-1:0]};
            `SIL_OFF_CNT_RX1: state_next.rdata = widen(state_reg.cnt_rx1);
            `SIL_OFF_CNT_ERR1: state_next.rdata = widen(state_reg.cnt_err1);
            `SIL_OFF_CNT_RX2: state_next.rdata = widen(state_reg.cnt_rx2);
            `SIL_OFF_CNT_ERR2: state_next.rdata = widen(state_reg.cnt_err2);
            default: state_next.rdata = 32'h0;
         endcase
      end

      // active-low indicator outputs
      state_next.run_n = ~run_lit;
      state_next.rx_n = ~rx_active;
      state_next.tx_n = ~tx_active;
      state_next.dlink_n = ~dlink_lit;
      state_next.err_n = ~err_lit;
      state_next.u1_n = ~u1_lit;
      state_next.u2_n = ~u2_lit;
      state_next.link1_n = ~link1_lit;
      state_next.link2_n = ~link2_lit;
      state_next.ler1_n = ~ler1_lit;
      state_next.ler2_n = ~ler2_lit;

      // spare port bit: high in standby, else output when direction bit is clear
      state_next.spare_oe = state_reg.standby | ~state_reg.pdir[`SIL_SPARE_BIT];
      state_next.spare_o = state_reg.standby | state_reg.pdata[`SIL_SPARE_BIT];
   end

   // ********************
   // registers
   // ********************
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= '0;
         state_reg.ctrl <= `SIL_RST_CTRL;
         state_reg.swval <= `SIL_RST_SWVAL;
         state_reg.pdir <= `SIL_RST_PDIR;
         state_reg.pfsel <= `SIL_RST_PFSEL;
         state_reg.pbuf <= `SIL_RST_PBUF;
         state_reg.pdata <= `SIL_RST_PDATA;
         state_reg.standby <= 1'b1;
         state_reg.run_n <= 1'b1;
         state_reg.rx_n <= 1'b1;
         state_reg.tx_n <= 1'b1;
         state_reg.dlink_n <= 1'b1;
         state_reg.err_n <= 1'b1;
         state_reg.u1_n <= 1'b1;
         state_reg.u2_n <= 1'b1;
         state_reg.link1_n <= 1'b1;
         state_reg.link2_n <= 1'b1;
         state_reg.ler1_n <= 1'b1;
         state_reg.ler2_n <= 1'b1;
         state_reg.spare_o <= 1'b1;
         state_reg.spare_oe <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ********************
   // outputs
   // ********************
   assign reg_rdata = state_reg.rdata;
   assign operating_indicator_n = state_reg.run_n;
   assign receive_indicator_n = state_reg.rx_n;
   assign send_indicator_n = state_reg.tx_n;
   assign cyclic_exchange_indicator_n = state_reg.dlink_n;
   assign station_fault_indicator_n = state_reg.err_n;
   assign custom_indicator_1_n = state_reg.u1_n;
   assign custom_indicator_2_n = state_reg.u2_n;
   assign port1_connected_out = state_reg.link1_n;
   assign port2_connected_out = state_reg.link2_n;
   assign port1_line_fault_n = state_reg.ler1_n;
   assign port2_line_fault_n = state_reg.ler2_n;
   assign spare_port_bit_o = state_reg.spare_o;
   assign spare_port_bit_oe = state_reg.spare_oe;
   assign bypass_mode = state_reg.bypass;

endmodule : sil_indicator

`default_nettype wire

/* File: testbench/sil_indicator_monitor.sv */
// status indicator block: port-level checker, bound into the top module
// assumes one clock ref_clk and outputs registered one cycle after their causes
`timescale 1ns/100ps
`default_nettype none

module sil_indicator_monitor (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic system_reset,
   input wire logic hw_failure,
   input wire logic int_watchdog_error,
   input wire logic own_station_error,
   input wire logic rx_active,
   input wire logic tx_active,
   input wire logic link_up_p1,
   input wire logic operating_indicator_n,
   input wire logic receive_indicator_n,
   input wire logic send_indicator_n,
   input wire logic cyclic_exchange_indicator_n,
   input wire logic station_fault_indicator_n,
   input wire logic custom_indicator_1_n,
   input wire logic custom_indicator_2_n,
   input wire logic port1_connected_out,
   input wire logic port2_connected_out,
   input wire logic port1_line_fault_n,
   input wire logic port2_line_fault_n,
   input wire logic bypass_mode
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   // ****************
   // assertions
   // ****************
   wire logic forced_off = operating_indicator_n & cyclic_exchange_indicator_n &
      custom_indicator_1_n & custom_indicator_2_n & port1_line_fault_n & port2_line_fault_n;

   a_power_on_off:
      assert property (!$past(resetn) |-> forced_off && station_fault_indicator_n &&
         receive_indicator_n && send_indicator_n && port1_connected_out && !bypass_mode)
      else $error("indicator lit right after power-on reset");
   a_sysrst_off:
      assert property (system_reset |=> forced_off && station_fault_indicator_n &&
         port1_connected_out && port2_connected_out && bypass_mode)
      else $error("system reset did not force indicators off");
   a_error_force:
      assert property ((own_station_error || int_watchdog_error) && !system_reset |=>
         !station_fault_indicator_n && forced_off && bypass_mode)
      else $error("error did not force the indicator set");
   a_hwfail_run:
      assert property (hw_failure |=> operating_indicator_n)
      else $error("operating lit during hardware failure");
   a_rx_follow:
      assert property ($past(resetn) |-> receive_indicator_n == !$past(rx_active))
      else $error("receive indicator does not follow reception");
   a_tx_follow:
      assert property ($past(resetn) |-> send_indicator_n == !$past(tx_active))
      else $error("send indicator does not follow sending");
   a_link_lit:
      assert property (link_up_p1 && !system_reset |=> !port1_connected_out)
      else $error("port 1 link indicator dark with link up");
   a_bypass_link:
      assert property (bypass_mode && !system_reset |=> !port1_connected_out &&
         !port2_connected_out)
      else $error("link indicators dark in bypass mode");
endmodule : sil_indicator_monitor

bind sil_indicator sil_indicator_monitor i_mon (.ref_clk, .resetn, .system_reset, .hw_failure,
   .int_watchdog_error, .own_station_error, .rx_active, .tx_active, .link_up_p1,
   .operating_indicator_n, .receive_indicator_n, .send_indicator_n,
   .cyclic_exchange_indicator_n, .station_fault_indicator_n, .custom_indicator_1_n,
   .custom_indicator_2_n, .port1_connected_out, .port2_connected_out, .port1_line_fault_n,
   .port2_line_fault_n, .bypass_mode);

`default_nettype wire

/* File: testbench/sil_indicator_bench.sv */
// status indicator block: self-checking bench
// assumes sil_indicator with a short blink period and the offsets of sil_map.svh
`timescale 1ns/100ps
`default_nettype none
`include "sil_map.svh"

module sil_indicator_bench;
   import sil_pkg::*;
   logic ref_clk, resetn, reg_wr, reg_rd, system_reset, hw_failure, int_watchdog_error;
   logic own_station_error, rx_active, tx_active, cyclic_running, link_up_p1, link_up_p2;
   logic rx_abnormal_p1, rx_abnormal_p2, loopback_p1, loopback_p2, rx_frame_p1;
   logic rx_err_frame_p1, rx_frame_p2, rx_err_frame_p2, external_watchdog_fault_n;
   logic spare_port_bit_i, spare_port_bit_o, spare_port_bit_oe, operating_indicator_n;
   logic receive_indicator_n, send_indicator_n, cyclic_exchange_indicator_n;
   logic station_fault_indicator_n, custom_indicator_1_n, custom_indicator_2_n;
   logic port1_connected_out, port2_connected_out, port1_line_fault_n, port2_line_fault_n;
   logic bypass_mode;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   int error_cnt, checked, n;

   sil_indicator #(.BLINK_HALF_CYCLES(4)) i_dut (.ref_clk, .resetn, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .system_reset, .hw_failure, .int_watchdog_error,
      .own_station_error, .rx_active, .tx_active, .cyclic_running, .link_up_p1, .link_up_p2,
      .rx_abnormal_p1, .rx_abnormal_p2, .loopback_p1, .loopback_p2, .rx_frame_p1,
      .rx_err_frame_p1, .rx_frame_p2, .rx_err_frame_p2, .external_watchdog_fault_n,
      .spare_port_bit_i, .spare_port_bit_o, .spare_port_bit_oe, .operating_indicator_n,
      .receive_indicator_n, .send_indicator_n, .cyclic_exchange_indicator_n,
      .station_fault_indicator_n, .custom_indicator_1_n, .custom_indicator_2_n,
      .port1_connected_out, .port2_connected_out, .port1_line_fault_n, .port2_line_fault_n,
      .bypass_mode);

   // ****************
   // helpers
   // ****************
   function automatic logic [31:0] ind();
      return {21'h0, port2_line_fault_n, port1_line_fault_n, port2_connected_out,
         port1_connected_out, custom_indicator_2_n, custom_indicator_1_n,
         station_fault_indicator_n, cyclic_exchange_indicator_n, send_indicator_n,
         receive_indicator_n, operating_indicator_n};
   endfunction : ind

   function automatic logic [31:0] umode(input sil_umode_e m);
      return {20'h0, m, m, 8'h00};
   endfunction : umode

   task automatic settle(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      settle(2);
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask : rdr

   task automatic toggles(output int t);
      logic [31:0] p;
      t = 0;
      p = ind();
      repeat (24) begin
         settle(1);
         if (ind() !== p) t++;
         p = ind();
      end
   endtask : toggles

   // ****************
   // scenarios
   // ****************
   task automatic t_regs();
      logic [7:0] a [7] = '{`SIL_OFF_CTRL, `SIL_OFF_SWVAL, `SIL_OFF_PDIR, `SIL_OFF_PFSEL,
         `SIL_OFF_PBUF, `SIL_OFF_PDATA, 8'h3c};
      logic [31:0] e [7] = '{32'h7f00, 32'h0, 32'hff, 32'h0, 32'h9000, 32'hff, 32'h0};
      chk("ind", 32'h7fe, ind());
      chk("spare_oe", 32'h1, spare_port_bit_oe);
      chk("spare_o", 32'h1, spare_port_bit_o);
      wr(8'h3c, 32'hffff_ffff);
      for (int i = 0; i < 7; i++) begin
         rdr(a[i]);
         chk("reset_value", e[i], rd);
      end
      wr(`SIL_OFF_PFSEL, 32'h5a);
      rdr(`SIL_OFF_PFSEL);
      chk("pfsel", 32'h5a, rd);
      wr(`SIL_OFF_PFSEL, 32'h0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_hw();
      @(posedge ref_clk);
      {rx_active, tx_active, link_up_p1, cyclic_running, rx_abnormal_p1, loopback_p2} <= '1;
      settle(2);
      chk("ind", 32'h170, ind());
      rdr(`SIL_OFF_STATUS);
      chk("status", 32'h68f, rd);
      toggles(n);
      chk("dlink_steady", 32'h0, n);
      @(posedge ref_clk);
      {rx_active, tx_active, cyclic_running, rx_abnormal_p1, loopback_p2} <= '0;
      toggles(n);
      chk("dlink_blink", 32'h1, n >= 4);
      @(posedge ref_clk);
      link_up_p1 <= 1'b0;
      settle(2);
      chk("ind", 32'h7fe, ind());
      $display("test hw done");
   endtask : t_hw

   task automatic t_err();
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk);
         rx_active <= 1'b1;
         case (k)
            0: own_station_error <= 1'b1;
            1: int_watchdog_error <= 1'b1;
            default: external_watchdog_fault_n <= 1'b0;
         endcase
         settle(5);
         chk("ind", 32'h66d, ind());
         chk("bypass", 32'h1, bypass_mode);
         @(posedge ref_clk);
         {rx_active, own_station_error, int_watchdog_error} <= '0;
         external_watchdog_fault_n <= 1'b1;
         settle(5);
         chk("ind", 32'h67e, ind());
         wr(`SIL_OFF_CTRL, 32'h1_7f00);
         chk("bypass", 32'h0, bypass_mode);
      end
      @(posedge ref_clk);
      hw_failure <= 1'b1;
      settle(2);
      chk("ind", 32'h7ff, ind());
      @(posedge ref_clk);
      hw_failure <= 1'b0;
      @(posedge ref_clk);
      {system_reset, rx_active} <= '1;
      settle(3);
      chk("ind", 32'h7fd, ind());
      rdr(`SIL_OFF_STATUS);
      chk("status", 32'h802, rd);
      @(posedge ref_clk);
      {system_reset, rx_active} <= '0;
      wr(`SIL_OFF_CTRL, 32'h1_7f00);
      chk("ind", 32'h7fe, ind());
      $display("test err done");
   endtask : t_err

   task automatic t_sw();
      wr(`SIL_OFF_CTRL, 32'h7f01);
      chk("ind", 32'h7ff, ind());
      wr(`SIL_OFF_SWVAL, 32'h1);
      chk("ind", 32'h7fe, ind());
      wr(`SIL_OFF_CTRL, 32'h7e00);
      chk("ind", 32'h7ff, ind());
      wr(`SIL_OFF_CTRL, 32'h7f00);
      wr(`SIL_OFF_SWVAL, umode(SIL_UM_ON));
      chk("ind", 32'h79e, ind());
      wr(`SIL_OFF_CTRL, 32'h5f00);
      chk("ind", 32'h7be, ind());
      wr(`SIL_OFF_SWVAL, umode(SIL_UM_BLINK));
      toggles(n);
      chk("user_blink", 32'h1, n >= 4);
      wr(`SIL_OFF_SWVAL, 32'hf00);
      chk("ind", 32'h7fe, ind());
      @(posedge ref_clk);
      rx_abnormal_p1 <= 1'b1;
      wr(`SIL_OFF_CTRL, 32'h7700);
      chk("ind", 32'h7fe, ind());
      wr(`SIL_OFF_CTRL, 32'h7f00);
      chk("ind", 32'h5fe, ind());
      @(posedge ref_clk);
      rx_abnormal_p1 <= 1'b0;
      wr(`SIL_OFF_SWVAL, 32'h0);
      $display("test sw done");
   endtask : t_sw

   task automatic t_port();
      logic [7:0] a [4] = '{`SIL_OFF_CNT_RX1, `SIL_OFF_CNT_ERR1, `SIL_OFF_CNT_RX2,
         `SIL_OFF_CNT_ERR2};
      logic [31:0] e [4] = '{32'h3, 32'h1, 32'h2, 32'h5};
      wr(`SIL_OFF_PDIR, 32'h7f);
      wr(`SIL_OFF_PDATA, 32'h7f);
      chk("spare", 32'h2, {spare_port_bit_oe, spare_port_bit_o});
      wr(`SIL_OFF_PDIR, 32'hff);
      chk("spare_oe", 32'h0, spare_port_bit_oe);
      @(posedge ref_clk);
      spare_port_bit_i <= 1'b0;
      settle(4);
      rdr(`SIL_OFF_PDATA);
      chk("spare_in", 32'h0, rd[7]);
      for (int i = 0; i < 6; i++) begin
         @(posedge ref_clk);
         rx_frame_p1 <= (i < 3);
         rx_err_frame_p1 <= (i < 1);
         rx_frame_p2 <= (i < 2);
         rx_err_frame_p2 <= (i < 5);
      end
      settle(1);
      for (int i = 0; i < 4; i++) begin
         rdr(a[i]);
         chk("frame_count", e[i], rd);
      end
      $display("test port done");
   endtask : t_port

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   // ****************
   // run
   // ****************
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      #100000;
      error_cnt++;
      $display("Error watchdog expected done seen hang");
      end_sim();
   end

   initial begin
      error_cnt = 0;
      checked = 0;
      {resetn, reg_wr, reg_rd, system_reset, hw_failure, int_watchdog_error, own_station_error,
         rx_active, tx_active, cyclic_running, link_up_p1, link_up_p2, rx_abnormal_p1,
         rx_abnormal_p2, loopback_p1, loopback_p2, rx_frame_p1, rx_err_frame_p1, rx_frame_p2,
         rx_err_frame_p2, reg_addr, reg_wdata} = '0;
      external_watchdog_fault_n = 1'b1;
      spare_port_bit_i = 1'b1;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      settle(3);
      t_regs();
      t_hw();
      t_err();
      t_sw();
      t_port();
      end_sim();
   end
endmodule : sil_indicator_bench

`default_nettype wire
